/* logic/pma_consts.svh */
// Purpose: Register offsets, bit positions and mode codes of the math accelerator
// Assumes: 8-bit register port with a 5-bit byte address
// Notes:   Definitions only
`ifndef PMA_CONSTS_SVH
`define PMA_CONSTS_SVH
// Register offsets
`define PMA_A_CON   5'h00
`define PMA_A_INL   5'h01
`define PMA_A_INH   5'h02
`define PMA_A_SETL  5'h03
`define PMA_A_SETH  5'h04
`define PMA_A_K1L   5'h05
`define PMA_A_K1H   5'h06
`define PMA_A_K2L   5'h07
`define PMA_A_K2H   5'h08
`define PMA_A_K3L   5'h09
`define PMA_A_K3H   5'h0a
`define PMA_A_OUT0  5'h0b
`define PMA_A_OUT1  5'h0c
`define PMA_A_OUT2  5'h0d
`define PMA_A_OUT3  5'h0e
`define PMA_A_OUT4  5'h0f
`define PMA_A_Z1L   5'h10
`define PMA_A_Z1H   5'h11
`define PMA_A_Z1U   5'h12
`define PMA_A_Z2L   5'h13
`define PMA_A_Z2H   5'h14
`define PMA_A_Z2U   5'h15
`define PMA_A_FLAG  5'h16
// Control and flag bit positions
`define PMA_EN_BIT   7
`define PMA_BUSY_BIT 6
`define PMA_DONE_BIT 0
`define PMA_OVF_BIT  1
// Mode codes
`define PMA_M_UMAC   3'h0
`define PMA_M_SMAC   3'h2
`define PMA_M_PID    3'h5
// Last step index of a controller calculation
`define PMA_PID_LAST 2'h2
`endif

/* logic/pma_pkg.sv */
// Purpose: Types shared by the math accelerator files
// Assumes: Nothing
// Notes:   Whole state of the top module is one packed struct
package pma_pkg;
  localparam int PMA_ACC_W = 35;

  typedef enum logic {ST_IDLE, ST_CALC} pma_st_t;

  typedef struct packed {
    pma_st_t               st;
    logic [1:0]            step;
    logic                  en;
    logic [2:0]            mode;
    logic [15:0]           inp;
    logic [15:0]           setp;
    logic [15:0]           k1;
    logic [15:0]           k2;
    logic [15:0]           k3;
    logic [PMA_ACC_W-1:0]  out;
    logic [PMA_ACC_W-1:0]  sum;
    logic [16:0]           err;
    logic [16:0]           z1;
    logic [16:0]           z2;
    logic                  ovf_run;
    logic                  done_f;
    logic                  ovf_f;
    logic [7:0]            rdata;
  } pma_state_t;
endpackage

/* logic/pma_mul.sv */
// Purpose: Signed multiplier feeding the accumulator
// Assumes: Operands already sign or zero extended by the caller
// Notes:   Full-width product, no rounding
`timescale 1ns/100ps
module pma_mul #(
  parameter int AW = 18,
  parameter int BW = 17
) (
  input  wire logic signed [AW-1:0]    a_i,
  input  wire logic signed [BW-1:0]    b_i,
  output logic signed [AW+BW-1:0]      p_o
);
  // Combinational product
  assign p_o = a_i * b_i;
endmodule

/* logic/pma_top.sv */
// Purpose: Math accelerator: three-term controller or multiply-and-add unit
// Assumes: Single clock, synchronous reset, byte-wide register port
// Notes:   One product per clock; controller takes three cycles, multiply-add one
`timescale 1ns/100ps
`include "pma_consts.svh"

// What this block does
// - Mode 101 runs the controller using three coefficients and error history
// - Four multiply-add modes: unsigned or signed, each with or without accumulation
// - Multiply-add gives (input plus set point) times coefficient one
// - Controller error is set point minus the new input
// - Errors times coefficients one, two, three are summed
// - Accumulating modes add onto the old output; others hold the latest result
// - Writing input low byte starts a run and sets busy at once
// - Busy stays set until the whole computation ends
// - On completion busy clears and the done flag sets
// - On overflow the output wraps and the overflow flag sets
// - Output and history are writable; a later run continues from them
// - Control holds enable bit 7, busy bit 6, mode bits 2-0
module pma_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             busy_o,
  output logic             calc_done_flag_o,
  output logic             calc_overflow_flag_o
);
  import pma_pkg::*;

  pma_state_t              s_r;
  pma_state_t              s_nxt;
  logic signed [17:0]      mul_a;
  logic signed [16:0]      mul_b;
  logic signed [34:0]      prod;
  logic                    sgn;
  logic                    pid;
  logic                    last;
  logic                    ovf_now;
  logic [35:0]             sum36;

  // Extend a 16-bit value to 17 bits, signed or unsigned
  function automatic logic [16:0] ext17(input logic [15:0] v, input logic sg);
    ext17 = {sg & v[15], v};
  endfunction

  // Extend a 17-bit value to 18 bits, signed or unsigned
  function automatic logic [17:0] ext18(input logic [16:0] v, input logic sg);
    ext18 = {sg & v[16], v};
  endfunction

  assign pid  = (s_r.mode == `PMA_M_PID);
  assign sgn  = s_r.mode[1] | pid;
  assign last = pid ? (s_r.step == `PMA_PID_LAST) : (s_r.step == 2'h0);

  // Operand selection for the current step
  always_comb begin
    mul_a = '0;
    mul_b = '0;
    if (!pid) begin
      mul_a = ext18(ext17(s_r.inp, sgn), sgn) + ext18(ext17(s_r.setp, sgn), sgn);
      mul_b = ext17(s_r.k1, sgn);
    end else begin
      unique case (s_r.step)
        2'h0: begin
          mul_a = ext18(s_r.err, 1'b1);
          mul_b = ext17(s_r.k1, 1'b1);
        end
        2'h1: begin
          mul_a = ext18(s_r.z1, 1'b1);
          mul_b = ext17(s_r.k2, 1'b1);
        end
        default: begin
          mul_a = ext18(s_r.z2, 1'b1);
          mul_b = ext17(s_r.k3, 1'b1);
        end
      endcase
    end
  end

  pma_mul #(.AW(18), .BW(17)) u_mul (
    .a_i (mul_a),
    .b_i (mul_b),
    .p_o (prod)
  );

  // 35-bit signed add with overflow check
  assign sum36   = {s_r.sum[34], s_r.sum} + {prod[34], prod};
  assign ovf_now = sum36[35] ^ sum36[34];

  // Next-state logic: register writes, start, calculation, read data
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;
    // Register reads, unmapped addresses read zero
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PMA_A_CON:  s_nxt.rdata = {s_r.en, s_r.st == ST_CALC, 3'h0, s_r.mode};
        `PMA_A_INL:  s_nxt.rdata = s_r.inp[7:0];
        `PMA_A_INH:  s_nxt.rdata = s_r.inp[15:8];
        `PMA_A_SETL: s_nxt.rdata = s_r.setp[7:0];
        `PMA_A_SETH: s_nxt.rdata = s_r.setp[15:8];
        `PMA_A_K1L:  s_nxt.rdata = s_r.k1[7:0];
        `PMA_A_K1H:  s_nxt.rdata = s_r.k1[15:8];
        `PMA_A_K2L:  s_nxt.rdata = s_r.k2[7:0];
        `PMA_A_K2H:  s_nxt.rdata = s_r.k2[15:8];
        `PMA_A_K3L:  s_nxt.rdata = s_r.k3[7:0];
        `PMA_A_K3H:  s_nxt.rdata = s_r.k3[15:8];
        `PMA_A_OUT0: s_nxt.rdata = s_r.out[7:0];
        `PMA_A_OUT1: s_nxt.rdata = s_r.out[15:8];
        `PMA_A_OUT2: s_nxt.rdata = s_r.out[23:16];
        `PMA_A_OUT3: s_nxt.rdata = s_r.out[31:24];
        `PMA_A_OUT4: s_nxt.rdata = {5'h00, s_r.out[34:32]};
        `PMA_A_Z1L:  s_nxt.rdata = s_r.z1[7:0];
        `PMA_A_Z1H:  s_nxt.rdata = s_r.z1[15:8];
        `PMA_A_Z1U:  s_nxt.rdata = {7'h00, s_r.z1[16]};
        `PMA_A_Z2L:  s_nxt.rdata = s_r.z2[7:0];
        `PMA_A_Z2H:  s_nxt.rdata = s_r.z2[15:8];
        `PMA_A_Z2U:  s_nxt.rdata = {7'h00, s_r.z2[16]};
        `PMA_A_FLAG: s_nxt.rdata = {6'h00, s_r.ovf_f, s_r.done_f};
        default:     s_nxt.rdata = 8'h00;
      endcase
    end
    // Register writes; busy bit is read-only
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PMA_A_CON: begin
          s_nxt.en   = reg_wdata_i[`PMA_EN_BIT];
          s_nxt.mode = reg_wdata_i[2:0];
        end
        `PMA_A_INL:  s_nxt.inp[7:0]   = reg_wdata_i;
        `PMA_A_INH:  s_nxt.inp[15:8]  = reg_wdata_i;
        `PMA_A_SETL: s_nxt.setp[7:0]  = reg_wdata_i;
        `PMA_A_SETH: s_nxt.setp[15:8] = reg_wdata_i;
        `PMA_A_K1L:  s_nxt.k1[7:0]    = reg_wdata_i;
        `PMA_A_K1H:  s_nxt.k1[15:8]   = reg_wdata_i;
        `PMA_A_K2L:  s_nxt.k2[7:0]    = reg_wdata_i;
        `PMA_A_K2H:  s_nxt.k2[15:8]   = reg_wdata_i;
        `PMA_A_K3L:  s_nxt.k3[7:0]    = reg_wdata_i;
        `PMA_A_K3H:  s_nxt.k3[15:8]   = reg_wdata_i;
        `PMA_A_OUT0: s_nxt.out[7:0]   = reg_wdata_i;
        `PMA_A_OUT1: s_nxt.out[15:8]  = reg_wdata_i;
        `PMA_A_OUT2: s_nxt.out[23:16] = reg_wdata_i;
        `PMA_A_OUT3: s_nxt.out[31:24] = reg_wdata_i;
        `PMA_A_OUT4: s_nxt.out[34:32] = reg_wdata_i[2:0];
        `PMA_A_Z1L:  s_nxt.z1[7:0]    = reg_wdata_i;
        `PMA_A_Z1H:  s_nxt.z1[15:8]   = reg_wdata_i;
        `PMA_A_Z1U:  s_nxt.z1[16]     = reg_wdata_i[0];
        `PMA_A_Z2L:  s_nxt.z2[7:0]    = reg_wdata_i;
        `PMA_A_Z2H:  s_nxt.z2[15:8]   = reg_wdata_i;
        `PMA_A_Z2U:  s_nxt.z2[16]     = reg_wdata_i[0];
        `PMA_A_FLAG: begin
          // Write one to clear; a same-cycle set below wins
          if (reg_wdata_i[`PMA_DONE_BIT]) s_nxt.done_f = 1'b0;
          if (reg_wdata_i[`PMA_OVF_BIT])  s_nxt.ovf_f  = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_wr_i && reg_addr_i == `PMA_A_INL && s_r.en && s_r.st == ST_IDLE
        && (!s_r.mode[2] || pid)) begin
      s_nxt.st      = ST_CALC;
      s_nxt.step    = 2'h0;
      s_nxt.ovf_run = 1'b0;
      // accumulating modes start from the old output
      s_nxt.sum     = s_r.mode[0] ? s_nxt.out : '0;
      // error is set point minus input
      s_nxt.err     = ext17(s_r.setp, 1'b1) - ext17(s_nxt.inp, 1'b1);
    end
    // one product per cycle until the last step
    if (s_r.st == ST_CALC) begin
      s_nxt.sum     = sum36[34:0];
      s_nxt.ovf_run = s_r.ovf_run | ovf_now;
      s_nxt.step    = s_r.step + 2'h1;
      if (last) begin
        s_nxt.st     = ST_IDLE;
        s_nxt.step   = 2'h0;
        s_nxt.out    = sum36[34:0];
        s_nxt.done_f = 1'b1;
        if (s_r.ovf_run | ovf_now) s_nxt.ovf_f = 1'b1;
        if (pid) begin
          s_nxt.z2 = s_r.z1;
          s_nxt.z1 = s_r.err;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign reg_rdata_o          = s_r.rdata;
  assign busy_o               = (s_r.st == ST_CALC);
  assign calc_done_flag_o     = s_r.done_f;
  assign calc_overflow_flag_o = s_r.ovf_f;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_busy_on_start: assert property (
    reg_wr_i && reg_addr_i == `PMA_A_INL && s_r.en && !busy_o && s_r.mode == `PMA_M_PID
    |=> busy_o) else $error("busy not raised by input low write");

  chk_pid_busy_len: assert property (
    $rose(busy_o) && pid |-> busy_o [*3] ##1 !busy_o)
    else $error("controller run not three cycles");

  chk_mac_busy_len: assert property (
    $rose(busy_o) && !pid |-> busy_o ##1 !busy_o)
    else $error("multiply-add run not one cycle");

  chk_done_on_end: assert property (
    $fell(busy_o) |-> calc_done_flag_o) else $error("done flag missing at end");

  chk_hist_shift: assert property (
    $fell(busy_o) && pid |-> s_r.z1 == $past(s_r.err) && s_r.z2 == $past(s_r.z1, 3))
    else $error("error history not shifted");

  chk_mac_result: assert property (
    busy_o && s_r.mode == `PMA_M_SMAC |=> s_r.out == $past(prod))
    else $error("non-accumulating result wrong");

  chk_err_value: assert property (
    $rose(busy_o) && pid |-> s_r.err == 17'(ext17(s_r.setp, 1'b1) - ext17(s_r.inp, 1'b1)))
    else $error("error value wrong");

  chk_ovf_flag: assert property (
    busy_o && last && ovf_now |=> calc_overflow_flag_o)
    else $error("overflow flag missing");

  chk_con_read: assert property (
    reg_rd_i && reg_addr_i == `PMA_A_CON && !reg_wr_i
    |=> reg_rdata_o[5:3] == 3'h0 && reg_rdata_o[6] == $past(busy_o)
        && reg_rdata_o[2:0] == $past(s_r.mode))
    else $error("control read wrong");

  chk_hist_write: assert property (
    reg_wr_i && reg_addr_i == `PMA_A_Z1L && !busy_o |=> s_r.z1[7:0] == $past(reg_wdata_i))
    else $error("history write lost");
endmodule

/* test/tb.sv */
// Purpose: Self-checking bench for the math accelerator register port
// Assumes: Design driven only through its byte register port and reset, busy and flag outputs also watched, one clock
// Notes:   Expected results come from a small arithmetic model kept in the bench
`timescale 1ns/100ps
`include "pma_consts.svh"
module tb;
  localparam logic [15:0] SP = 16'h0100;
  localparam logic [15:0] KA = 16'h0002;
  localparam logic [15:0] KB = 16'hffff;
  localparam logic [15:0] KC = 16'h0003;
  logic               clk = 1'b0;
  logic               rst_i = 1'b1;
  logic [4:0]         addr = 5'h00;
  logic [7:0]         wdata = 8'h00;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [7:0]         rdata;
  logic               busy;
  logic               done_f;
  logic               ovf_f;
  int                 error_cnt = 0;
  int                 n_tests = 0;
  logic [39:0]        v;
  logic signed [34:0] eo;
  logic signed [16:0] e;
  logic signed [16:0] z1;
  logic signed [16:0] z2;
  logic [7:0]         cw [3] = '{8'h87, 8'h84, 8'h00};
  logic [15:0]        ins [3] = '{16'h0080, 16'h0200, 16'hff00};

  // Clock of 20 ns period
  always #10 clk = ~clk;

  pma_top pma_top_i (.core_clk_i(clk), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .busy_o(busy), .calc_done_flag_o(done_f), .calc_overflow_flag_o(ovf_f));

  // Counts and verdict, then end of run
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr_b(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Byte writes low byte first at rising addresses
  task automatic wr_n(input logic [4:0] a, input int n, input logic [39:0] val);
    for (int i = 0; i < n; i++) wr_b(a + 5'(i), val[8*i +: 8]);
  endtask

  // Byte reads; data taken in the single cycle after the strobe
  task automatic rd_n(input logic [4:0] a, input int n, output logic [39:0] val);
    val = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      addr <= a + 5'(i);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 val[8*i +: 8] = rdata;
    end
  endtask

  // Clear flags, load input high then low, count busy cycles under a bound
  task automatic run(input logic [15:0] in, input int exp_cyc);
    int n;
    n = 0;
    wr_b(`PMA_A_FLAG, 8'h03);
    wr_b(`PMA_A_INH, in[15:8]);
    wr_b(`PMA_A_INL, in[7:0]);
    #1 chk("busy at start", busy, 1'b1);
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    chk("busy cycles", 40'(n), 40'(exp_cyc));
    chk("done flag", done_f, 1'b1);
  endtask

  // Multiply-add model: operands widened by signedness, product kept to 35 bits
  function automatic logic [34:0] mac(input logic [2:0] m, input logic [15:0] a,
                                      input logic [15:0] s, input logic [15:0] k);
    logic [34:0] x;
    logic [34:0] y;
    x = m[1] ? 35'(signed'(a)) + 35'(signed'(s)) : 35'(a) + 35'(s);
    y = m[1] ? 35'(signed'(k)) : 35'(k);
    return x * y;
  endfunction

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_i <= 1'b0;
    rd_n(`PMA_A_CON, 1, v);
    chk("control reset", v, 40'h0);
    wr_b(`PMA_A_CON, 8'hff);
    rd_n(`PMA_A_CON, 1, v);
    chk("control fields", v, 40'h87);
    wr_b(5'h1f, 8'h5a);
    rd_n(5'h1f, 1, v);
    chk("unmapped read", v, 40'h0);
    // Reserved modes and disabled unit start nothing
    foreach (cw[i]) begin
      wr_b(`PMA_A_CON, cw[i]);
      wr_b(`PMA_A_INL, 8'h11);
      #1 chk("busy not started", busy, 1'b0);
    end
    // Four multiply-add modes, two runs each
    wr_n(`PMA_A_SETL, 2, 40'h8000);
    wr_n(`PMA_A_K1L, 2, 40'hfffd);
    eo = '0;
    for (int m = 0; m < 4; m++) begin
      wr_b(`PMA_A_CON, 8'(m));
      wr_b(`PMA_A_CON, 8'h80 | 8'(m));
      for (int r = 0; r < 2; r++) begin
        eo = (m[0] ? eo : 35'h0) + mac(3'(m), 16'h8001, 16'h8000, 16'hfffd);
        run(16'h8001, 1);
        rd_n(`PMA_A_OUT0, 5, v);
        chk("mac out", v[34:0], {eo});
        chk("no overflow", ovf_f, 1'b0);
      end
    end
    // Controller from a restored state
    wr_n(`PMA_A_K1L, 2, 40'(KA));
    wr_n(`PMA_A_K2L, 2, 40'(KB));
    wr_n(`PMA_A_K3L, 2, 40'(KC));
    wr_n(`PMA_A_SETL, 2, 40'(SP));
    z1 = -17'sd10;
    z2 = 17'sd5;
    eo = 35'sd100;
    wr_n(`PMA_A_OUT0, 5, {5'h0, eo});
    wr_n(`PMA_A_Z1L, 3, {23'h0, z1});
    wr_n(`PMA_A_Z2L, 3, {23'h0, z2});
    wr_b(`PMA_A_CON, 8'h05);
    wr_b(`PMA_A_CON, 8'h85);
    foreach (ins[i]) begin
      e = 17'(signed'(SP)) - 17'(signed'(ins[i]));
      eo = eo + 35'(signed'(KA)) * 35'(e) + 35'(signed'(KB)) * 35'(z1)
              + 35'(signed'(KC)) * 35'(z2);
      z2 = z1;
      z1 = e;
      run(ins[i], 3);
      rd_n(`PMA_A_OUT0, 5, v);
      chk("pid out", v[34:0], {eo});
      rd_n(`PMA_A_Z1L, 3, v);
      chk("previous error", v[16:0], {z1});
      rd_n(`PMA_A_Z2L, 3, v);
      chk("older error", v[16:0], {z2});
    end
    // Largest positive output plus one wraps and raises overflow
    wr_b(`PMA_A_CON, 8'h03);
    wr_b(`PMA_A_CON, 8'h83);
    wr_n(`PMA_A_SETL, 2, 40'h0);
    wr_n(`PMA_A_K1L, 2, 40'h1);
    wr_n(`PMA_A_OUT0, 5, 40'h03_ffff_ffff);
    run(16'h0001, 1);
    rd_n(`PMA_A_OUT0, 5, v);
    chk("wrapped out", v[34:0], 35'h4_0000_0000);
    rd_n(`PMA_A_FLAG, 1, v);
    chk("flags", v, 40'h03);
    // Write one clears both flags
    wr_b(`PMA_A_FLAG, 8'h03);
    rd_n(`PMA_A_FLAG, 1, v);
    chk("flags cleared", v, 40'h00);
    // Busy bit of the control register while a controller run is under way
    wr_b(`PMA_A_CON, 8'h05);
    wr_b(`PMA_A_CON, 8'h85);
    wr_b(`PMA_A_INH, 8'h00);
    wr_b(`PMA_A_INL, 8'h00);
    rd_n(`PMA_A_CON, 1, v);
    chk("busy bit read", v, 40'hc5);
    repeat (3) @(posedge clk);
    #1 chk("busy after run", busy, 1'b0);
    report_and_stop();
  end
endmodule
